// File: rtl/bidir_fifo_defines.svh
`ifndef BIDIR_FIFO_DEFINES_SVH
`define BIDIR_FIFO_DEFINES_SVH

// Width of each port data bus and of every stored word
`define DATA_WIDTH 36
// Words held by each queue
`define QUEUE_DEPTH 64
// Almost-flag offset X for offset-select codes msb,lsb
`define OFFSET_SEL_11 5'h10
`define OFFSET_SEL_10 5'h0C
`define OFFSET_SEL_01 5'h08
`define OFFSET_SEL_00 5'h04
`define OFFSET_RESET 5'h04
// Flag reset value, order empty_n, almost_empty_n, almost_full_n, full_n
`define FLAGS_RESET 4'h2
// Mail registers reset to empty
`define MAIL_EMPTY_RESET 2'h3

`endif

// File: rtl/bidir_fifo_pkg.sv
`include "bidir_fifo_defines.svh"

package bidir_fifo_pkg;

   typedef logic [`DATA_WIDTH-1:0] word_type;

   typedef struct packed {
      logic     select_n;
      logic     write_not_read;
      logic     enable;
      logic     mail_select;
      word_type data;
   } port_in_type;

   typedef struct packed {
      logic empty_n;
      logic almost_empty_n;
      logic almost_full_n;
      logic full_n;
   } flags_type;

endpackage : bidir_fifo_pkg

// File: rtl/port_sampler.sv
`timescale 1ns/1ns

// Brings one host port into the system clock domain and marks its clock rises
module port_sampler (
   input  wire logic                        i_clock,
   input  wire logic                        i_resetn,
   input  wire logic                        i_port_clock,
   input  wire bidir_fifo_pkg::port_in_type i_port,
   output bidir_fifo_pkg::port_in_type      o_port,
   output logic                            o_edge
);

   logic                        clk_s1_q;
   logic                        clk_s2_q;
   logic                        clk_s3_q;
   bidir_fifo_pkg::port_in_type port_s1_q;
   bidir_fifo_pkg::port_in_type port_s2_q;

   // Pins are sampled in the same two stages as the port clock, so the
   // controls seen at a detected rise are those that stood around it
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         // Stages reset high, so a port clock already high at release is no rise
         clk_s1_q  <= 1'b1;
         clk_s2_q  <= 1'b1;
         clk_s3_q  <= 1'b1;
         port_s1_q <= '0;
         port_s2_q <= '0;
      end else begin
         clk_s1_q  <= i_port_clock;
         clk_s2_q  <= clk_s1_q;
         clk_s3_q  <= clk_s2_q;
         port_s1_q <= i_port;
         port_s2_q <= port_s1_q;
      end
   end

   // A port clock rise too close to a sampling edge is simply seen one cycle later
   assign o_edge = clk_s2_q & ~clk_s3_q;
   assign o_port = port_s2_q;

endmodule : port_sampler

// File: rtl/bidirectional_clocked_fifo.sv
`timescale 1ns/1ns
`include "bidir_fifo_defines.svh"

module bidirectional_clocked_fifo #(
   parameter int DEPTH = `QUEUE_DEPTH
) (
   input  wire logic                   I_CLOCK,
   input  wire logic                   I_RESETN,
   input  wire logic                   I_OFFSET_SELECT_LSB,
   input  wire logic                   I_OFFSET_SELECT_MSB,
   input  wire logic                   I_PORT_A_CLOCK,
   input  wire logic                   I_PORT_A_SELECT_N,
   input  wire logic                   I_PORT_A_WRITE_NOT_READ,
   input  wire logic                   I_PORT_A_ENABLE,
   input  wire logic                   I_PORT_A_MAIL_SELECT,
   input  wire logic [`DATA_WIDTH-1:0] I_PORT_A_DATA_BUS,
   output logic      [`DATA_WIDTH-1:0] O_PORT_A_DATA_BUS,
   output logic                        O_PORT_A_DATA_OE,
   input  wire logic                   I_PORT_B_CLOCK,
   input  wire logic                   I_PORT_B_SELECT_N,
   input  wire logic                   I_PORT_B_WRITE_NOT_READ,
   input  wire logic                   I_PORT_B_ENABLE,
   input  wire logic                   I_PORT_B_MAIL_SELECT,
   input  wire logic [`DATA_WIDTH-1:0] I_PORT_B_DATA_BUS,
   output logic      [`DATA_WIDTH-1:0] O_PORT_B_DATA_BUS,
   output logic                        O_PORT_B_DATA_OE,
   output logic                        O_A_TO_B_FULL_N,
   output logic                        O_A_TO_B_ALMOST_FULL_N,
   output logic                        O_A_TO_B_EMPTY_N,
   output logic                        O_A_TO_B_ALMOST_EMPTY_N,
   output logic                        O_B_TO_A_FULL_N,
   output logic                        O_B_TO_A_ALMOST_FULL_N,
   output logic                        O_B_TO_A_EMPTY_N,
   output logic                        O_B_TO_A_ALMOST_EMPTY_N,
   output logic                        O_A_TO_B_MAIL_EMPTY,
   output logic                        O_B_TO_A_MAIL_EMPTY
);

   localparam int PW = $clog2(DEPTH) + 1;
   localparam int AW = PW - 1;

   // Index 0 is port A and the a-to-b queue/mail, index 1 port B and b-to-a
   bidir_fifo_pkg::port_in_type pin_port [2];
   bidir_fifo_pkg::port_in_type ctl      [2];
   logic [1:0]                  edge_p;

   logic [1:0]                  rst_sync_q;
   logic                        rst_n;
   logic [1:0]                  fs_s1_q;
   logic [1:0]                  fs_s2_q;
   logic [4:0]                  x_q;
   logic                        x_loaded_q;

   bidir_fifo_pkg::word_type    mem_q     [2][DEPTH];
   logic [PW-1:0]               wptr_q    [2];
   logic [PW-1:0]               rptr_q    [2];
   bidir_fifo_pkg::word_type    out_reg_q [2];
   bidir_fifo_pkg::word_type    mail_q    [2];
   logic [1:0]                  mail_empty_q;
   bidir_fifo_pkg::flags_type   s1_q      [2];
   bidir_fifo_pkg::flags_type   s2_q      [2];
   bidir_fifo_pkg::word_type    dout_q    [2];
   logic [1:0]                  oe_q;

   logic [1:0]                  wr_op;
   logic [1:0]                  rd_op;
   logic [1:0]                  q_wr;
   logic [1:0]                  q_rd;
   logic [1:0]                  mail_wr;
   logic [1:0]                  mail_rd;
   logic [PW-1:0]               cnt       [2];
   bidir_fifo_pkg::flags_type   fw        [2];
   bidir_fifo_pkg::flags_type   fr        [2];

   function automatic logic [4:0] offset_decode(input logic [1:0] sel);
      unique case (sel)
         2'b11:   offset_decode = `OFFSET_SEL_11;
         2'b10:   offset_decode = `OFFSET_SEL_10;
         2'b01:   offset_decode = `OFFSET_SEL_01;
         default: offset_decode = `OFFSET_SEL_00;
      endcase
   endfunction : offset_decode

   function automatic bidir_fifo_pkg::flags_type queue_flags(input logic [PW-1:0] c,
                                                            input logic [4:0]    x);
      logic [PW-1:0] xw;
      xw = PW'(x);
      queue_flags.empty_n        = (c != '0);
      queue_flags.almost_empty_n = (c > xw);
      queue_flags.almost_full_n  = (c < PW'(DEPTH) - xw);
      queue_flags.full_n         = (c != PW'(DEPTH));
   endfunction : queue_flags

   assign pin_port[0] = '{I_PORT_A_SELECT_N, I_PORT_A_WRITE_NOT_READ, I_PORT_A_ENABLE,
                          I_PORT_A_MAIL_SELECT, I_PORT_A_DATA_BUS};
   assign pin_port[1] = '{I_PORT_B_SELECT_N, I_PORT_B_WRITE_NOT_READ, I_PORT_B_ENABLE,
                          I_PORT_B_MAIL_SELECT, I_PORT_B_DATA_BUS};

   port_sampler u_port_a (
      .i_clock      (I_CLOCK),
      .i_resetn     (I_RESETN),
      .i_port_clock (I_PORT_A_CLOCK),
      .i_port       (pin_port[0]),
      .o_port       (ctl[0]),
      .o_edge       (edge_p[0])
   );

   port_sampler u_port_b (
      .i_clock      (I_CLOCK),
      .i_resetn     (I_RESETN),
      .i_port_clock (I_PORT_B_CLOCK),
      .i_port       (pin_port[1]),
      .o_port       (ctl[1]),
      .o_edge       (edge_p[1])
   );

   // Reset asserts at once but releases synchronously, so a release at any
   // moment cannot leave half the state machines out of reset
   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         fs_s1_q <= 2'h0;
         fs_s2_q <= 2'h0;
      end else begin
         fs_s1_q <= {I_OFFSET_SELECT_MSB, I_OFFSET_SELECT_LSB};
         fs_s2_q <= fs_s1_q;
      end
   end

   // Offset is caught once, on the first cycle after reset release
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         x_q        <= `OFFSET_RESET;
         x_loaded_q <= 1'b0;
      end else if (!x_loaded_q) begin
         x_q        <= offset_decode(fs_s2_q);
         x_loaded_q <= 1'b1;
      end
   end

   always_comb begin
      for (int p = 0; p < 2; p++) begin
         wr_op[p] = edge_p[p] & ~ctl[p].select_n & ctl[p].write_not_read & ctl[p].enable;
         rd_op[p] = edge_p[p] & ~ctl[p].select_n & ~ctl[p].write_not_read & ctl[p].enable;
         q_wr[p] = wr_op[p] & ~ctl[p].mail_select & s2_q[p].full_n;
         q_rd[p] = rd_op[1-p] & ~ctl[1-p].mail_select & s2_q[p].empty_n;
         mail_wr[p] = wr_op[p] & ctl[p].mail_select & mail_empty_q[p];
         mail_rd[p] = rd_op[1-p] & ctl[1-p].mail_select;
         cnt[p] = wptr_q[p] - rptr_q[p];
         // Own-side moves are counted at once; the far side's need two stages
         fw[p] = queue_flags(cnt[p] + PW'(q_wr[p]), x_q);
         fr[p] = queue_flags(cnt[p] - PW'(q_rd[p]), x_q);
      end
   end

   // Storage needs no reset; pointers alone decide what is valid
   always_ff @(posedge I_CLOCK) begin
      for (int d = 0; d < 2; d++) begin
         if (q_wr[d]) begin
            mem_q[d][wptr_q[d][AW-1:0]] <= ctl[d].data;
         end
      end
   end

   // One clock domain holds both pointers, so plain binary is crossing-safe
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         for (int d = 0; d < 2; d++) begin
            wptr_q[d]    <= '0;
            rptr_q[d]    <= '0;
            out_reg_q[d] <= '0;
         end
      end else begin
         for (int d = 0; d < 2; d++) begin
            if (q_wr[d]) begin
               wptr_q[d] <= wptr_q[d] + PW'(1);
            end
            if (q_rd[d]) begin
               rptr_q[d]    <= rptr_q[d] + PW'(1);
               out_reg_q[d] <= mem_q[d][rptr_q[d][AW-1:0]];
            end
         end
      end
   end

   // Writer flags step on the writing port's clock, reader flags on the reader's
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         for (int d = 0; d < 2; d++) begin
            s1_q[d] <= bidir_fifo_pkg::flags_type'(`FLAGS_RESET);
            s2_q[d] <= bidir_fifo_pkg::flags_type'(`FLAGS_RESET);
         end
      end else begin
         for (int d = 0; d < 2; d++) begin
            if (edge_p[d]) begin
               s1_q[d].full_n        <= fw[d].full_n;
               s1_q[d].almost_full_n <= fw[d].almost_full_n;
               s2_q[d].full_n        <= s1_q[d].full_n & (fw[d].full_n | ~q_wr[d]);
               s2_q[d].almost_full_n <= s1_q[d].almost_full_n &
                                        (fw[d].almost_full_n | ~q_wr[d]);
            end
            if (edge_p[1-d]) begin
               s1_q[d].empty_n        <= fr[d].empty_n;
               s1_q[d].almost_empty_n <= fr[d].almost_empty_n;
               s2_q[d].empty_n        <= s1_q[d].empty_n & (fr[d].empty_n | ~q_rd[d]);
               s2_q[d].almost_empty_n <= s1_q[d].almost_empty_n &
                                         (fr[d].almost_empty_n | ~q_rd[d]);
            end
         end
      end
   end

   // A write needs the register already empty, and it wins over a read's set in the same cycle
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         mail_empty_q <= `MAIL_EMPTY_RESET;
         mail_q[0]    <= '0;
         mail_q[1]    <= '0;
      end else begin
         for (int m = 0; m < 2; m++) begin
            if (mail_wr[m]) begin
               mail_q[m]       <= ctl[m].data;
               mail_empty_q[m] <= 1'b0;
            end else if (mail_rd[m]) begin
               mail_empty_q[m] <= 1'b1;
            end
         end
      end
   end

   // Read data is shown whatever the enable; a read rise with enable moves queue data, a far-port mail write moves mail data
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         oe_q      <= 2'h0;
         dout_q[0] <= '0;
         dout_q[1] <= '0;
      end else begin
         for (int p = 0; p < 2; p++) begin
            oe_q[p]   <= ~ctl[p].select_n & ~ctl[p].write_not_read;
            dout_q[p] <= ctl[p].mail_select ? mail_q[1-p] : out_reg_q[1-p];
         end
      end
   end

   assign O_PORT_A_DATA_BUS       = dout_q[0];
   assign O_PORT_A_DATA_OE        = oe_q[0];
   assign O_PORT_B_DATA_BUS       = dout_q[1];
   assign O_PORT_B_DATA_OE        = oe_q[1];
   assign O_A_TO_B_FULL_N         = s2_q[0].full_n;
   assign O_A_TO_B_ALMOST_FULL_N  = s2_q[0].almost_full_n;
   assign O_A_TO_B_EMPTY_N        = s2_q[0].empty_n;
   assign O_A_TO_B_ALMOST_EMPTY_N = s2_q[0].almost_empty_n;
   assign O_B_TO_A_FULL_N         = s2_q[1].full_n;
   assign O_B_TO_A_ALMOST_FULL_N  = s2_q[1].almost_full_n;
   assign O_B_TO_A_EMPTY_N        = s2_q[1].empty_n;
   assign O_B_TO_A_ALMOST_EMPTY_N = s2_q[1].almost_empty_n;
   assign O_A_TO_B_MAIL_EMPTY     = mail_empty_q[0];
   assign O_B_TO_A_MAIL_EMPTY     = mail_empty_q[1];

   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (!rst_n);

   a_reset_flags: assert property ($rose(rst_n) |-> (s2_q[0] == 4'h2) && (s2_q[1] == 4'h2)
      && (wptr_q[0] == '0) && (rptr_q[1] == '0))
      else $error("Queue state not cleared by reset");

   a_mail_reset: assert property ($rose(rst_n) |-> mail_empty_q == 2'h3)
      else $error("Mail registers not empty after reset");

   a_full_rise: assert property ($rose(s2_q[0].full_n) |-> $past(edge_p[0])
      && $past(s1_q[0].full_n))
      else $error("Full flag rose without two writer clock stages");

   a_offset_load: assert property ($rose(x_loaded_q) |-> x_q == offset_decode($past(fs_s2_q)))
      else $error("Offset not loaded from select pins");

   a_bus_tristate: assert property ((ctl[1].select_n || ctl[1].write_not_read) |=> !oe_q[1])
      else $error("Port B bus driven outside read select");

   a_queue_store: assert property (q_wr[0] |=> mem_q[0][$past(wptr_q[0][AW-1:0])]
      == $past(ctl[0].data))
      else $error("Port A write not stored");

   // A port B mail write in the same cycle leaves fresh mail behind
   a_mail_read: assert property (rd_op[0] && ctl[0].mail_select && !mail_wr[1]
      |=> mail_empty_q[1])
      else $error("Port A mail read did not mark mail empty");

   a_empty_hold: assert property (!s2_q[1].empty_n |=> $stable(rptr_q[1])
      && $stable(out_reg_q[1]))
      else $error("Empty queue was read");

   a_mail_lock: assert property (!mail_empty_q[0] |=> $stable(mail_q[0]))
      else $error("Full mail register overwritten");

   a_full_block: assert property (!s2_q[1].full_n |=> $stable(wptr_q[1]))
      else $error("Full queue was written");

   a_fill_bound: assert property (cnt[0] <= PW'(DEPTH) && cnt[1] <= PW'(DEPTH))
      else $error("Queue fill beyond depth");

endmodule : bidirectional_clocked_fifo

// File: sim/port_host.sv
`timescale 1ns/1ns

// Host on one port: free-running port clock, one operation per port clock rise
module port_host #(
   parameter int HALF = 5
) (
   input  wire logic                   i_clock,
   output logic                        o_port_clock,
   output bidir_fifo_pkg::port_in_type o_port
);
   initial begin
      o_port_clock = 1'b0;
      o_port = '{1'b1, 1'b1, 1'b0, 1'b0, 36'h0};
      forever begin
         repeat (HALF) @(posedge i_clock);
         #1 o_port_clock = ~o_port_clock;
      end
   end

   // Controls move only in the low half, so they are steady across the rise and its detection
   task automatic op(input logic sel_n, input logic wnr, input logic en, input logic mail,
                     input bidir_fifo_pkg::word_type data);
      @(negedge o_port_clock);
      @(posedge i_clock);
      #1;
      o_port = '{sel_n, wnr, en, mail, wnr ? data : ~o_port.data};
      @(negedge o_port_clock);
      @(posedge i_clock);
      #1;
      o_port.enable = 1'b0;
      // A released bus must not keep its last value
      o_port.data = ~o_port.data;
   endtask : op
endmodule : port_host

// File: sim/test_bidirectional_clocked_fifo.sv
`timescale 1ns/1ns

module test_bidirectional_clocked_fifo;
   localparam int DEPTH = 64;
   logic                        clock;
   logic                        resetn;
   logic [1:0]                  fsel;
   logic                        clk_a;
   logic                        clk_b;
   bidir_fifo_pkg::port_in_type pa;
   bidir_fifo_pkg::port_in_type pb;
   logic [35:0]                 dout_a;
   logic [35:0]                 dout_b;
   logic                        oe_a;
   logic                        oe_b;
   logic [3:0]                  fl_ab;
   logic [3:0]                  fl_ba;
   logic [1:0]                  mail_fl;
   int                          err_count;
   int                          checks_done;
   int                          x_val;
   int                          seed;
   bidir_fifo_pkg::word_type    q[2][$];
   bidir_fifo_pkg::word_type    out_m[2];
   bidir_fifo_pkg::word_type    mail_m[2];
   logic                        mail_e[2];

   bidirectional_clocked_fifo #(.DEPTH(DEPTH)) dut_u (
      .I_CLOCK                (clock),
      .I_RESETN               (resetn),
      .I_OFFSET_SELECT_LSB    (fsel[0]),
      .I_OFFSET_SELECT_MSB    (fsel[1]),
      .I_PORT_A_CLOCK         (clk_a),
      .I_PORT_A_SELECT_N      (pa.select_n),
      .I_PORT_A_WRITE_NOT_READ(pa.write_not_read),
      .I_PORT_A_ENABLE        (pa.enable),
      .I_PORT_A_MAIL_SELECT   (pa.mail_select),
      .I_PORT_A_DATA_BUS      (pa.data),
      .O_PORT_A_DATA_BUS      (dout_a),
      .O_PORT_A_DATA_OE       (oe_a),
      .I_PORT_B_CLOCK         (clk_b),
      .I_PORT_B_SELECT_N      (pb.select_n),
      .I_PORT_B_WRITE_NOT_READ(pb.write_not_read),
      .I_PORT_B_ENABLE        (pb.enable),
      .I_PORT_B_MAIL_SELECT   (pb.mail_select),
      .I_PORT_B_DATA_BUS      (pb.data),
      .O_PORT_B_DATA_BUS      (dout_b),
      .O_PORT_B_DATA_OE       (oe_b),
      .O_A_TO_B_FULL_N        (fl_ab[0]),
      .O_A_TO_B_ALMOST_FULL_N (fl_ab[1]),
      .O_A_TO_B_EMPTY_N       (fl_ab[3]),
      .O_A_TO_B_ALMOST_EMPTY_N(fl_ab[2]),
      .O_B_TO_A_FULL_N        (fl_ba[0]),
      .O_B_TO_A_ALMOST_FULL_N (fl_ba[1]),
      .O_B_TO_A_EMPTY_N       (fl_ba[3]),
      .O_B_TO_A_ALMOST_EMPTY_N(fl_ba[2]),
      .O_A_TO_B_MAIL_EMPTY    (mail_fl[0]),
      .O_B_TO_A_MAIL_EMPTY    (mail_fl[1])
   );

   port_host #(.HALF(5)) host_a (.i_clock(clock), .o_port_clock(clk_a), .o_port(pa));
   port_host #(.HALF(6)) host_b (.i_clock(clock), .o_port_clock(clk_b), .o_port(pb));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   function automatic logic [3:0] exp_flags(input int n);
      return {n != 0, n > x_val, n < DEPTH - x_val, n != DEPTH};
   endfunction : exp_flags

   function automatic bidir_fifo_pkg::word_type rnd();
      logic [63:0] r;
      r = {$urandom, $urandom};
      return r[35:0];
   endfunction : rnd

   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_flags();
      repeat (32) @(posedge clock);
      #1;
      chk({32'h0, fl_ab}, {32'h0, exp_flags(q[0].size())});
      chk({32'h0, fl_ba}, {32'h0, exp_flags(q[1].size())});
      chk({34'h0, mail_fl}, {34'h0, mail_e[1], mail_e[0]});
   endtask : chk_flags

   // Port p: 0 writes a-to-b and reads b-to-a, 1 the other way round
   task automatic xfer(input int p, input logic sel_n, input logic wnr, input logic en,
                       input logic mail, input bidir_fifo_pkg::word_type d);
      if (p == 0) host_a.op(sel_n, wnr, en, mail, d);
      else host_b.op(sel_n, wnr, en, mail, d);
      if (!sel_n && en && wnr && mail && mail_e[p]) begin
         mail_m[p] = d;
         mail_e[p] = 1'b0;
      end else if (!sel_n && en && wnr && !mail && q[p].size() < DEPTH) q[p].push_back(d);
      else if (!sel_n && en && !wnr && mail) mail_e[1-p] = 1'b1;
      else if (!sel_n && en && !wnr && q[1-p].size() > 0) out_m[p] = q[1-p].pop_front();
      repeat (2) @(posedge clock);
      #1;
      chk({35'h0, p ? oe_b : oe_a}, {35'h0, !sel_n && !wnr});
      if (!sel_n && !wnr) chk(p ? dout_b : dout_a, mail ? mail_m[1-p] : out_m[p]);
   endtask : xfer

   task automatic do_reset(input int code);
      @(posedge clock);
      #1;
      resetn = 1'b0;
      fsel = code[1:0];
      // Long enough for five rises of the slower port clock
      repeat (60) @(posedge clock);
      chk({26'h0, fl_ab, fl_ba, mail_fl}, {26'h0, 8'h22, 2'h3});
      chk({34'h0, oe_a, oe_b}, 36'h0);
      @(posedge clock);
      #1;
      resetn = 1'b1;
      x_val = 4 * (code + 1);
      q[0].delete();
      q[1].delete();
      mail_e = '{1'b1, 1'b1};
      out_m = '{default: '0};
      mail_m = '{default: '0};
      repeat (4) @(posedge clock);
      #1;
      chk({35'h0, fl_ab[0]}, 36'h0);
      chk_flags();
   endtask : do_reset

   task automatic report_and_stop();
      $display("Checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      // About twice the longest expected run
      #300000;
      err_count++;
      $display("Error at %0t: watchdog expired", $time);
      report_and_stop();
   end

   initial begin
      resetn = 1'b0;
      fsel = 2'h0;
      err_count = 0;
      checks_done = 0;
      x_val = 4;
      seed = $urandom(1);
      // Each later reset lands on a b-to-a queue that still holds one word
      for (int code = 0; code < 4; code++) begin
         do_reset(code);
         xfer(0, 1'b1, 1'b1, 1'b1, 1'b0, rnd());
         xfer(0, 1'b0, 1'b1, 1'b0, 1'b0, rnd());
         for (int i = 0; i <= DEPTH; i++) begin
            xfer(0, 1'b0, 1'b1, 1'b1, 1'b0, rnd());
            if (i == 0) chk({35'h0, fl_ab[3]}, 36'h0);
            chk_flags();
         end
         for (int i = 0; i <= DEPTH; i++) begin
            xfer(1, 1'b0, 1'b0, 1'b1, 1'b0, 36'h0);
            chk_flags();
         end
         for (int i = 0; i < x_val + 2; i++) begin
            xfer(1, 1'b0, 1'b1, 1'b1, 1'b0, rnd());
            chk_flags();
         end
         for (int i = 0; i < x_val + 2; i++) begin
            xfer(0, 1'b0, 1'b0, 1'b1, 1'b0, 36'h0);
            chk_flags();
         end
         xfer(0, 1'b0, 1'b1, 1'b1, 1'b1, rnd());
         xfer(0, 1'b0, 1'b1, 1'b1, 1'b1, rnd());
         chk_flags();
         xfer(1, 1'b0, 1'b0, 1'b0, 1'b1, 36'h0);
         xfer(1, 1'b0, 1'b0, 1'b1, 1'b1, 36'h0);
         xfer(1, 1'b0, 1'b1, 1'b1, 1'b1, rnd());
         xfer(0, 1'b0, 1'b0, 1'b1, 1'b1, 36'h0);
         chk_flags();
         xfer(1, 1'b0, 1'b1, 1'b1, 1'b0, rnd());
      end
      report_and_stop();
   end
endmodule : test_bidirectional_clocked_fifo
